// ### dv/mcb_banks_properties.sv
// concurrent checks on the register port and event outputs of the logging banks
`timescale 1ns/1ps

module mcb_banks_chk (
	input wire clk,
	input wire nrst,
	input wire [31:0] msr_index,
	input wire msr_rd_en,
	input wire msr_wr_en,
	input wire [63:0] msr_wdata,
	input wire [63:0] msr_rdata,
	input wire msr_ack,
	input wire msr_miss,
	input wire all_read_data_report_enable,
	input wire ls_err_valid,
	input wire ls_mce,
	input wire watchdog_expired,
	input wire fr_mce,
	input wire [31:0] nb_ctl_cfg,
	input wire [31:0] nb_status_lo,
	input wire [31:0] nb_status_hi,
	input wire nb_ctl_wr,
	input wire [63:0] nb_wdata
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// any access on the register port
	wire req = msr_rd_en | msr_wr_en;
	// index falls inside the bank window
	wire mapped = (msr_index >= 32'h0000_040a) && (msr_index <= 32'h0000_0417);
	ack_on_req_a: assert property (req |=> msr_ack) else $error("access not acked");
	ack_idle_a: assert property (!req |=> !msr_ack) else $error("ack without access");
	miss_unmapped_a: assert property (req && !mapped |=> msr_ack && msr_miss) else $error("miss absent");
	miss_mapped_a: assert property (req && mapped |=> !msr_miss) else $error("miss on mapped index");
	misc_zero_a: assert property (msr_rd_en && msr_index == 32'h0000_040b |=> msr_rdata == 64'h0) else $error("misc not zero");
	ls_gate_a: assert property (ls_err_valid && !all_read_data_report_enable |=> !ls_mce) else $error("ls not gated");
	ls_cause_a: assert property (ls_mce |-> $past(ls_err_valid)) else $error("ls event uncaused");
	fr_cause_a: assert property (fr_mce |-> $past(watchdog_expired)) else $error("fr event uncaused");
	nb_ctl_mirror_a: assert property (msr_rd_en && msr_index == 32'h0000_0410 |=> msr_rdata == {32'h0, $past(nb_ctl_cfg)}) else $error("nb ctl mirror");
	nb_status_mirror_a: assert property (msr_rd_en && msr_index == 32'h0000_0411 |=> msr_rdata == $past({nb_status_hi, nb_status_lo})) else $error("nb status mirror");
	nb_fwd_a: assert property (msr_wr_en && msr_index == 32'h0000_0410 |=> nb_ctl_wr && nb_wdata == $past(msr_wdata)) else $error("nb write lost");
endmodule

bind mcb_banks mcb_banks_chk chk_u (.*);

// ### dv/mcb_banks_tb.sv
// randomised self-checking bench for the logging banks
`timescale 1ns/1ps

module mcb_banks_tb;
	logic clk = 0, nrst = 0, msr_rd_en = 0, msr_wr_en = 0, status_write_enable = 0;
	logic all_read_data_report_enable = 0, bu_log_valid = 0, ls_err_valid = 0, watchdog_expired = 0;
	logic ls_err_is_store = 0, ls_err_is_io = 0, ls_err_addr_valid = 0, ls_err_ctx_corrupt = 0;
	logic [31:0] msr_index = 0, nb_ctl_cfg = 0, nb_status_lo = 0, nb_status_hi = 0;
	logic [31:0] nb_addr_lo = 0, nb_addr_hi = 0, nb_thresh_lo = 0;
	logic [1:0] bu_log_kind = 0, bu_l2_size = 0;
	logic [3:0] bu_log_way = 0;
	logic [7:0] nb_blk_ptr = 0;
	logic [47:0] bu_log_addr = 0, ls_err_addr = 0, fr_next_ip = 0;
	logic [63:0] msr_wdata = 0, fr_impl_status = 0, msr_rdata, nb_wdata;
	logic msr_ack, msr_miss, ls_mce, fr_mce, nb_ctl_wr, nb_status_wr, nb_addr_wr, nb_thresh_wr;
	int failures = 0;
	int num_checks = 0;

	mcb_banks dut_u (.*);

	// 200 MHz clock
	initial forever #2.5 clk = ~clk;

	task automatic tally_and_finish();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// one-cycle request, then wait a bounded time for the ack
	task automatic acc(input logic [31:0] idx, input logic wr, input logic [63:0] d);
		int n;
		@(negedge clk);
		msr_index = idx;
		msr_rd_en = !wr;
		msr_wr_en = wr;
		msr_wdata = d;
		@(negedge clk);
		msr_rd_en = 0;
		msr_wr_en = 0;
		n = 0;
		while (msr_ack !== 1'b1 && n < 4) begin
			@(negedge clk);
			n++;
		end
		if (msr_ack !== 1'b1) begin
			failures++;
			tally_and_finish();
		end
	endtask

	task automatic rd(input logic [31:0] idx, input logic [63:0] exp);
		acc(idx, 1'b0, 64'h0);
		chk(msr_rdata, exp);
	endtask

	// bus-class status word: valid, uncorrected, flags, code
	function automatic logic [63:0] st_exp(logic av, logic pc, logic [11:0] code);
		return {1'b1, 1'b0, 1'b1, 2'b0, av, pc, 45'h0, code};
	endfunction

	// bus-unit address kept per error kind
	function automatic logic [63:0] bu_exp(logic [1:0] k, logic [47:0] a, logic [3:0] w, logic [1:0] s);
		logic [63:0] m;
		m = ((64'h1 << (13 + s)) - 1) & ~64'h003f;
		if (k == 2'h0) return {16'h0, a} & ~64'h003f;
		if (k == 2'h1) return ({16'h0, a} & m) | w;
		return {16'h0, a} & ~64'h0003;
	endfunction

	initial begin
		logic [63:0] r;
		logic [47:0] a;
		logic st, io, av, pc, e;
		int i;
		void'($urandom(32'h18b2));
		repeat (20) @(negedge clk);
		nrst = 1;
		rd(32'h0000_040c, 64'h0);
		rd(32'h0000_0414, 64'h0);
		rd(32'h0000_040f, 64'h0);
		acc(32'h0000_040b, 1'b1, '1);
		rd(32'h0000_040b, 64'h0);
		acc(32'h0000_0500, 1'b0, 64'h0);
		chk(msr_miss, 64'h1);
		// software writes to address registers persist
		r = {$urandom, $urandom};
		acc(32'h0000_040a, 1'b1, r);
		rd(32'h0000_040a, r);
		acc(32'h0000_040e, 1'b1, ~r);
		rd(32'h0000_040e, ~r);
		// load/store errors under random enables; first pass has global enable off
		for (i = 0; i < 12; i++) begin
			r = {$urandom, $urandom};
			acc(32'h0000_040c, 1'b1, r);
			rd(32'h0000_040c, r & 64'h0003);
			all_read_data_report_enable = (i < 2) ? i[0] : 1'($urandom);
			{st, io, av, pc} = 4'($urandom);
			a = {16'($urandom), $urandom};
			@(negedge clk);
			ls_err_valid = 1;
			ls_err_is_store = st;
			ls_err_is_io = io;
			ls_err_addr_valid = av;
			ls_err_ctx_corrupt = pc;
			ls_err_addr = a;
			@(negedge clk);
			ls_err_valid = 0;
			e = all_read_data_report_enable & (st ? r[0] : r[1]);
			chk(ls_mce, e);
			if (e) begin
				rd(32'h0000_040d, st_exp(av, pc, st ? 12'h843 : io ? 12'h83b : 12'h833));
				if (av) rd(32'h0000_040e, a);
			end
		end
		// watchdog expiry, enabled then masked
		for (i = 0; i < 2; i++) begin
			acc(32'h0000_0414, 1'b1, {63'h0, ~i[0]});
			@(negedge clk);
			watchdog_expired = 1;
			fr_next_ip = {16'($urandom), $urandom};
			fr_impl_status = {$urandom, $urandom};
			@(negedge clk);
			watchdog_expired = 0;
			chk(fr_mce, i == 0);
			if (i == 0) begin
				rd(32'h0000_0415, st_exp(1'b1, 1'b1, 12'hf0f));
				rd(32'h0000_0416, fr_next_ip);
				rd(32'h0000_0417, fr_impl_status);
			end
		end
		// reset in mid-run puts both control registers back to zero
		acc(32'h0000_040c, 1'b1, '1);
		rd(32'h0000_040c, 64'h0000_0000_0000_0003);
		acc(32'h0000_0414, 1'b1, '1);
		nrst = 0;
		repeat (2) @(negedge clk);
		chk(msr_ack, 64'h0000_0000_0000_0000);
		nrst = 1;
		rd(32'h0000_040c, 64'h0000_0000_0000_0000);
		rd(32'h0000_0414, 64'h0000_0000_0000_0000);
		// bus-unit address capture for each kind, three times each, with a random cache size
		for (i = 0; i < 9; i++) begin
			@(negedge clk);
			bu_log_valid = 1;
			bu_log_kind = 2'(i % 3);
			bu_l2_size = 2'($urandom);
			bu_log_way = 4'($urandom);
			bu_log_addr = {16'($urandom), $urandom};
			@(negedge clk);
			bu_log_valid = 0;
			rd(32'h0000_040a, bu_exp(bu_log_kind, bu_log_addr, bu_log_way, bu_l2_size));
		end
		// northbridge mirrors follow the live words
		{nb_ctl_cfg, nb_status_lo, nb_status_hi} = {$urandom, $urandom, $urandom};
		{nb_addr_lo, nb_addr_hi, nb_thresh_lo} = {$urandom, $urandom, $urandom};
		nb_blk_ptr = 8'($urandom) | 8'h01;
		acc(32'h0000_0410, 1'b1, r);
		chk(nb_ctl_wr, 64'h0000_0000_0000_0001);
		chk(nb_wdata, r);
		acc(32'h0000_0413, 1'b1, ~r);
		chk(nb_thresh_wr, 64'h0000_0000_0000_0001);
		chk(nb_wdata, ~r);
		acc(32'h0000_0412, 1'b1, r);
		chk(nb_addr_wr, 64'h0000_0000_0000_0001);
		rd(32'h0000_0410, {32'h0, nb_ctl_cfg});
		rd(32'h0000_0411, {nb_status_hi, nb_status_lo});
		rd(32'h0000_0412, {nb_addr_hi, nb_addr_lo});
		rd(32'h0000_0413, {nb_thresh_lo, nb_blk_ptr, 24'h0});
		// software walks to the next misc block from the non-zero pointer
		chk({msr_rdata[31:24], 3'b000} + 64'h0000_0000_c000_0400, {nb_blk_ptr, 3'b000} + 64'h0000_0000_c000_0400);
		// status writes land only with the core's permission
		status_write_enable = 1;
		acc(32'h0000_040d, 1'b1, r);
		rd(32'h0000_040d, r);
		acc(32'h0000_0411, 1'b1, r);
		chk(nb_status_wr, 64'h0000_0000_0000_0001);
		status_write_enable = 0;
		acc(32'h0000_040d, 1'b1, ~r);
		rd(32'h0000_040d, r);
		acc(32'h0000_0411, 1'b1, r);
		chk(nb_status_wr, 64'h0000_0000_0000_0000);
		tally_and_finish();
	end
endmodule

// ### pkg/mcb_consts.vh
// constants for the machine-check logging banks two to five
`ifndef MCB_CONSTS_VH
`define MCB_CONSTS_VH

// register indices on the model-specific register port
`define MCB_BU_ERROR_ADDRESS 32'h0000_040a
`define MCB_BU_ERROR_MISC 32'h0000_040b
`define MCB_LS_REPORT_CONTROL 32'h0000_040c
`define MCB_LS_ERROR_STATUS 32'h0000_040d
`define MCB_LS_ERROR_ADDRESS 32'h0000_040e
`define MCB_LS_ERROR_MISC 32'h0000_040f
`define MCB_NB_REPORT_CONTROL_MIRROR 32'h0000_0410
`define MCB_NB_ERROR_STATUS_MIRROR 32'h0000_0411
`define MCB_NB_ERROR_ADDRESS_MIRROR 32'h0000_0412
`define MCB_NB_THRESHOLD_MISC_FIRST 32'h0000_0413
`define MCB_FR_REPORT_CONTROL 32'h0000_0414
`define MCB_FR_ERROR_STATUS 32'h0000_0415
`define MCB_FR_ERROR_ADDRESS 32'h0000_0416
`define MCB_FR_ERROR_MISC 32'h0000_0417

// reset values
`define MCB_RESET_ZERO 64'h0000_0000_0000_0000

// control bit positions
`define MCB_STORE_READ_DATA_BIT 0
`define MCB_LOAD_READ_DATA_BIT 1
`define MCB_CORE_WATCHDOG_BIT 0

// status word field positions
`define MCB_ST_VALID 63
`define MCB_ST_UNCORRECTED 61
`define MCB_ST_ADDRESS_VALID 58
`define MCB_ST_CONTEXT_CORRUPT 57
`define MCB_ST_SYND_VALID 54
`define MCB_ST_CORRECTED_ECC 46
`define MCB_ST_UNCORRECTABLE_ECC 45
`define MCB_ST_SCRUB 40
`define MCB_ST_EXT_HI 19
`define MCB_ST_EXT_LO 16

// bus error code fields: 0000 1PPT RRRR IILL
`define MCB_EC_BUS_MARK 12'h800
`define MCB_PP_SOURCE 2'h0
`define MCB_PP_GENERIC 2'h3
`define MCB_RR_GENERIC 4'h0
`define MCB_RR_LOAD 4'h3
`define MCB_RR_STORE 4'h4
`define MCB_II_MEMORY 2'h0
`define MCB_II_IO 2'h2
`define MCB_II_GENERIC 2'h3
`define MCB_LL_GENERIC 2'h3
`define MCB_EXT_NONE 4'h0

// bus-unit error kinds on the capture port
`define MCB_BU_KIND_PHYS 2'h0
`define MCB_BU_KIND_TAG 2'h1
`define MCB_BU_KIND_PDC 2'h2

// northbridge misc pointer field
`define MCB_NB_PTR_HI 31
`define MCB_NB_PTR_LO 24

`endif

// ### src/mcb_banks.v
// machine-check logging banks two to five behind the model-specific register port
`timescale 1ns/1ps
`include "mcb_consts.vh"

module mcb_banks #(
	parameter ADDR_W = 48, // width of captured addresses
	parameter DATA_W = 64 // register width
) (
	input wire clk,
	input wire nrst,
	// register port
	input wire [31:0] msr_index,
	input wire msr_rd_en,
	input wire msr_wr_en,
	input wire [DATA_W-1:0] msr_wdata,
	output reg [DATA_W-1:0] msr_rdata,
	output reg msr_ack,
	output reg msr_miss,
	// status write permission from the core
	input wire status_write_enable,
	// bus-unit side
	input wire all_read_data_report_enable,
	input wire bu_log_valid,
	input wire [1:0] bu_log_kind,
	input wire [ADDR_W-1:0] bu_log_addr,
	input wire [3:0] bu_log_way,
	input wire [1:0] bu_l2_size,
	// load/store side
	input wire ls_err_valid,
	input wire ls_err_is_store,
	input wire ls_err_is_io,
	input wire ls_err_addr_valid,
	input wire ls_err_ctx_corrupt,
	input wire [ADDR_W-1:0] ls_err_addr,
	output reg ls_mce,
	// fetch/retire side
	input wire watchdog_expired,
	input wire [ADDR_W-1:0] fr_next_ip,
	input wire [DATA_W-1:0] fr_impl_status,
	output reg fr_mce,
	// northbridge configuration words, one shared copy
	input wire [31:0] nb_ctl_cfg,
	input wire [31:0] nb_status_lo,
	input wire [31:0] nb_status_hi,
	input wire [31:0] nb_addr_lo,
	input wire [31:0] nb_addr_hi,
	input wire [31:0] nb_thresh_lo,
	input wire [7:0] nb_blk_ptr,
	output reg nb_ctl_wr,
	output reg nb_status_wr,
	output reg nb_addr_wr,
	output reg nb_thresh_wr,
	output reg [DATA_W-1:0] nb_wdata
);

	// bank registers; logged ones carry no reset and read as unknown until the
	// first log or, for all but the fetch/retire misc, software write after a cold reset
	reg [DATA_W-1:0] bu_error_address;
	reg [DATA_W-1:0] ls_error_status;
	reg [DATA_W-1:0] ls_error_address;
	reg [DATA_W-1:0] fr_error_status;
	reg [DATA_W-1:0] fr_error_address;
	reg [DATA_W-1:0] fr_error_misc;
	reg [1:0] ls_report_control; // store and load enables
	reg fr_report_control; // watchdog enable

	// decoded accesses
	// only the writable registers decode a write strobe; writes to the local misc
	// registers and to unmapped indices are acked but change nothing
	wire wr_bu_addr = msr_wr_en && (msr_index == `MCB_BU_ERROR_ADDRESS);
	wire wr_ls_ctl = msr_wr_en && (msr_index == `MCB_LS_REPORT_CONTROL);
	wire wr_ls_status = msr_wr_en && (msr_index == `MCB_LS_ERROR_STATUS);
	wire wr_ls_addr = msr_wr_en && (msr_index == `MCB_LS_ERROR_ADDRESS);
	wire wr_fr_ctl = msr_wr_en && (msr_index == `MCB_FR_REPORT_CONTROL);
	wire wr_fr_status = msr_wr_en && (msr_index == `MCB_FR_ERROR_STATUS);
	wire wr_fr_addr = msr_wr_en && (msr_index == `MCB_FR_ERROR_ADDRESS);

	// reporting gates
	// a load and a store share one error pulse; the store flag picks the enable
	// limitation: the global enable is a plain outside level, so a change to it
	// applies to the very next error with no ordering guard
	wire ls_store_en = ls_report_control[`MCB_STORE_READ_DATA_BIT];
	wire ls_load_en = ls_report_control[`MCB_LOAD_READ_DATA_BIT];
	// enables only count while the global read-data enable is on
	wire ls_log = ls_err_valid && all_read_data_report_enable &&
		(ls_err_is_store ? ls_store_en : ls_load_en);
	wire fr_log = watchdog_expired && fr_report_control;

	// bus-unit tag index mask, one bit per index position
	// smaller caches hold fewer index bits, so upper index bits are masked
	// rather than shifted; the way always sits in 3:0 and bits 5:4 read zero
	wire [9:0] tag_keep;
	wire [ADDR_W-1:0] bu_tag_word;
	genvar gi;
	generate
		for (gi = 0; gi < 10; gi = gi + 1) begin : g_tag
			// one compare per index bit; the bound moves with the l2 size code
			// bit 6+gi kept when gi is at or below the bound of 6 plus l2 size
			assign tag_keep[gi] = (gi <= 6 + {2'b00, bu_l2_size});
		end
	endgenerate
	assign bu_tag_word = {{(ADDR_W-16){1'b0}}, bu_log_addr[15:6] & tag_keep, 2'b00, bu_log_way};

	// formatted bus-unit address by error kind
	// the kind code arrives with the log pulse and is not stored
	reg [ADDR_W-1:0] bu_fmt;
	always @* begin
		case (bu_log_kind)
			`MCB_BU_KIND_PHYS: begin
				bu_fmt = {bu_log_addr[ADDR_W-1:6], 6'h00};
			end
			`MCB_BU_KIND_TAG: begin
				bu_fmt = bu_tag_word;
			end
			`MCB_BU_KIND_PDC: begin
				bu_fmt = {bu_log_addr[ADDR_W-1:2], 2'b00};
			end
			default: begin
				// reserved kind code: treated as a physical address error
				bu_fmt = {bu_log_addr[ADDR_W-1:6], 6'h00};
			end
		endcase
	end

	// load/store signature
	// store errors are always memory space; loads follow the io flag
	wire [63:0] ls_sig;
	wire [63:0] fr_sig;
	mcb_status_enc u_ls_enc (
		.participation(`MCB_PP_SOURCE),
		.timeout(1'b0),
		.request(ls_err_is_store ? `MCB_RR_STORE : `MCB_RR_LOAD),
		.mem_io((ls_err_is_store || !ls_err_is_io) ? `MCB_II_MEMORY : `MCB_II_IO),
		.address_valid(ls_err_addr_valid),
		.context_corrupt(ls_err_ctx_corrupt),
		.status_word(ls_sig)
	);

	// watchdog signature: generic participation, timed out
	// fixed inputs: every watchdog log looks the same apart from address and misc
	mcb_status_enc u_fr_enc (
		.participation(`MCB_PP_GENERIC),
		.timeout(1'b1),
		.request(`MCB_RR_GENERIC),
		.mem_io(`MCB_II_GENERIC),
		.address_valid(1'b1),
		.context_corrupt(1'b1),
		.status_word(fr_sig)
	);

	// control registers, defined at reset
	// reset to zero so no error is reported until software opts in
	// only the enable bits are stored; reserved bits read back as zero
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ls_report_control <= 2'b00;
			fr_report_control <= 1'b0;
		end else begin
			// reserved upper bits are dropped
			if (wr_ls_ctl) begin
				ls_report_control <= msr_wdata[1:0];
			end
			if (wr_fr_ctl) begin
				fr_report_control <= msr_wdata[`MCB_CORE_WATCHDOG_BIT];
			end
		end
	end

	// logged registers carry no reset; a log beats a same-cycle write
	// so an error is never lost to a racing write; the write is dropped
	always @(posedge clk) begin
		// bus-unit address
		if (bu_log_valid) begin
			bu_error_address <= {{(DATA_W-ADDR_W){1'b0}}, bu_fmt};
		end else if (wr_bu_addr) begin
			bu_error_address <= msr_wdata;
		end
		// load/store status and address
		if (ls_log) begin
			// address captured whether or not the valid flag is set
			ls_error_status <= ls_sig;
			ls_error_address <= {{(DATA_W-ADDR_W){1'b0}}, ls_err_addr};
		end else begin
			// status writes need the core's permission, address writes do not
			if (wr_ls_status && status_write_enable) begin
				ls_error_status <= msr_wdata;
			end
			if (wr_ls_addr) begin
				ls_error_address <= msr_wdata;
			end
		end
		// fetch/retire status, address and misc
		if (fr_log) begin
			fr_error_status <= fr_sig;
			fr_error_address <= {{(DATA_W-ADDR_W){1'b0}}, fr_next_ip};
			// misc takes the raw implementation status word as is
			fr_error_misc <= fr_impl_status;
		end else begin
			// same permission rule as the load/store status
			if (wr_fr_status && status_write_enable) begin
				fr_error_status <= msr_wdata;
			end
			if (wr_fr_addr) begin
				fr_error_address <= msr_wdata;
			end
		end
	end

	// machine-check pulses toward the core
	// one-cycle pulses; the core is expected to latch them itself
	// cleared by reset so no stray event follows a reset
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ls_mce <= 1'b0;
			fr_mce <= 1'b0;
		end else begin
			ls_mce <= ls_log;
			fr_mce <= fr_log;
		end
	end

	// read mux; the northbridge words are one shared copy, not per core
	// reads have no side effects, so polling a bank never disturbs a log
	reg [DATA_W-1:0] next_rdata;
	reg next_miss;
	always @* begin
		next_miss = 1'b0;
		case (msr_index)
			`MCB_BU_ERROR_ADDRESS: begin
				next_rdata = bu_error_address;
			end
			`MCB_BU_ERROR_MISC: begin
				next_rdata = `MCB_RESET_ZERO;
			end
			`MCB_LS_REPORT_CONTROL: begin
				next_rdata = {62'h0, ls_report_control};
			end
			`MCB_LS_ERROR_STATUS: begin
				next_rdata = ls_error_status;
			end
			`MCB_LS_ERROR_ADDRESS: begin
				next_rdata = ls_error_address;
			end
			`MCB_LS_ERROR_MISC: begin
				next_rdata = `MCB_RESET_ZERO;
			end
			`MCB_NB_REPORT_CONTROL_MIRROR: begin
				next_rdata = {32'h0, nb_ctl_cfg};
			end
			`MCB_NB_ERROR_STATUS_MIRROR: begin
				next_rdata = {nb_status_hi, nb_status_lo};
			end
			`MCB_NB_ERROR_ADDRESS_MIRROR: begin
				next_rdata = {nb_addr_hi, nb_addr_lo};
			end
			`MCB_NB_THRESHOLD_MISC_FIRST: begin
				// pointer field read-only; low 24 bits reserved and read zero
				next_rdata = {nb_thresh_lo, nb_blk_ptr, 24'h00_0000};
			end
			`MCB_FR_REPORT_CONTROL: begin
				next_rdata = {63'h0, fr_report_control};
			end
			`MCB_FR_ERROR_STATUS: begin
				next_rdata = fr_error_status;
			end
			`MCB_FR_ERROR_ADDRESS: begin
				next_rdata = fr_error_address;
			end
			`MCB_FR_ERROR_MISC: begin
				next_rdata = fr_error_misc;
			end
			default: begin
				// unmapped index: zero data, flagged
				next_rdata = `MCB_RESET_ZERO;
				next_miss = 1'b1;
			end
		endcase
	end

	// answer one cycle after the request
	// any access is acked, mapped or not, so software never waits on a bad index
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			msr_rdata <= `MCB_RESET_ZERO;
			msr_ack <= 1'b0;
			msr_miss <= 1'b0;
		end else begin
			msr_ack <= msr_rd_en || msr_wr_en;
			msr_miss <= (msr_rd_en || msr_wr_en) && next_miss;
			// data held until the next read
			// rdata is left alone on writes so a read value can be picked up late
			if (msr_rd_en) begin
				msr_rdata <= next_rdata;
			end
		end
	end

	// writes forwarded to the northbridge copies; pointer stays read-only
	// the northbridge registers live outside; this bank only passes writes on
	// the status forward also needs the core's permission, like local status
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			nb_ctl_wr <= 1'b0;
			nb_status_wr <= 1'b0;
			nb_addr_wr <= 1'b0;
			nb_thresh_wr <= 1'b0;
			nb_wdata <= `MCB_RESET_ZERO;
		end else begin
			nb_ctl_wr <= msr_wr_en && (msr_index == `MCB_NB_REPORT_CONTROL_MIRROR);
			nb_status_wr <= msr_wr_en && (msr_index == `MCB_NB_ERROR_STATUS_MIRROR) && status_write_enable;
			nb_addr_wr <= msr_wr_en && (msr_index == `MCB_NB_ERROR_ADDRESS_MIRROR);
			nb_thresh_wr <= msr_wr_en && (msr_index == `MCB_NB_THRESHOLD_MISC_FIRST);
			if (msr_wr_en) begin
				nb_wdata <= msr_wdata;
			end
		end
	end

endmodule

// ### src/mcb_status_enc.v
// builds a bus-class machine-check status word from its fields
`timescale 1ns/1ps
`include "mcb_consts.vh"

module mcb_status_enc (
	input wire [1:0] participation,
	input wire timeout,
	input wire [3:0] request,
	input wire [1:0] mem_io,
	input wire address_valid,
	input wire context_corrupt,
	output reg [63:0] status_word
);

	// fixed fields: valid, uncorrected, no syndrome, no ecc, no scrub
	always @* begin
		status_word = `MCB_RESET_ZERO;
		status_word[`MCB_ST_VALID] = 1'b1;
		status_word[`MCB_ST_UNCORRECTED] = 1'b1;
		status_word[`MCB_ST_ADDRESS_VALID] = address_valid;
		status_word[`MCB_ST_CONTEXT_CORRUPT] = context_corrupt;
		status_word[`MCB_ST_SYND_VALID] = 1'b0;
		status_word[`MCB_ST_CORRECTED_ECC] = 1'b0;
		status_word[`MCB_ST_UNCORRECTABLE_ECC] = 1'b0;
		status_word[`MCB_ST_SCRUB] = 1'b0;
		status_word[`MCB_ST_EXT_HI:`MCB_ST_EXT_LO] = `MCB_EXT_NONE;
		// error code: bus mark, participation, timeout, request, space, level
		status_word[11:0] = `MCB_EC_BUS_MARK | {1'b0, participation, timeout, request, mem_io, `MCB_LL_GENERIC};
	end

endmodule
